// ---- dphy_timing_pkg.sv ----
// shared constants, types and helpers for the d-phy timing override bank
`default_nettype none

package dphy_timing_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CLK_PREPARE = 8'h40;
   localparam logic [7:0] IDX_CLK_ZERO = 8'h41;
   localparam logic [7:0] IDX_CLK_TRAIL = 8'h42;
   localparam logic [7:0] IDX_CLK_POST = 8'h43;
   localparam logic [7:0] IDX_HS_PREPARE = 8'h44;
   localparam logic [7:0] IDX_HS_ZERO = 8'h45;
   localparam logic [7:0] IDX_LANE_RATE = 8'h48;
   localparam logic [7:0] IDX_OVERRIDE_STATUS = 8'h49;

   // field layout of every timing register
   localparam int OVERRIDE_BIT = 7;
   localparam int VALUE_MSB = 6;
   localparam int VALUE_W = 7;
   localparam int NUM_PARAMS = 6;
   localparam int RATE_W = 2;

   // parameter slots in the timing vector
   localparam int SLOT_CLK_PREPARE = 0;
   localparam int SLOT_CLK_ZERO = 1;
   localparam int SLOT_CLK_TRAIL = 2;
   localparam int SLOT_CLK_POST = 3;
   localparam int SLOT_HS_PREPARE = 4;
   localparam int SLOT_HS_ZERO = 5;

   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef logic [NUM_PARAMS-1:0][VALUE_W-1:0] timing_vec_type;

   typedef enum logic [RATE_W-1:0] {
      RATE_800 = 2'h0,
      RATE_400 = 2'h1,
      RATE_1200 = 2'h2,
      RATE_1600 = 2'h3
   } rate_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [2:0] prot;
   } axi_addr_type;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } axi_wdata_type;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [1:0] resp;
   } axi_rdata_type;

   ////////////////////////////////////////////////////////////////////////////////
   // derived timing per rate and reset values (slot 5 first)
   localparam timing_vec_type DERIVED_800 = {7'h0c, 7'h06, 7'h0a, 7'h0b, 7'h1b, 7'h05};
   localparam timing_vec_type DERIVED_400 = {7'h07, 7'h04, 7'h0d, 7'h08, 7'h0e, 7'h03};
   localparam timing_vec_type DERIVED_1200 = {7'h12, 7'h09, 7'h09, 7'h0f, 7'h28, 7'h07};
   localparam timing_vec_type DERIVED_1600 = {7'h18, 7'h0b, 7'h08, 7'h13, 7'h36, 7'h09};
   localparam rate_type RATE_RESET = RATE_800;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
   endfunction : byte_addr

endpackage : dphy_timing_pkg

`default_nettype wire

// ---- timing_derive.sv ----
// automatic timing derivation from the selected lane rate
`timescale 1ns/1ps
`default_nettype none

module timing_derive
   import dphy_timing_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire rate_type i_rate,
   output timing_vec_type o_derived
);

   function automatic timing_vec_type lookup(input rate_type rate);
      case (rate)
         RATE_400: lookup = DERIVED_400;
         RATE_1200: lookup = DERIVED_1200;
         RATE_1600: lookup = DERIVED_1600;
         default: lookup = DERIVED_800;
      endcase
   endfunction : lookup

   // RULE_09: recompute on rate
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_derived <= DERIVED_800;
      end else begin
         o_derived <= lookup(i_rate);
      end
   end

endmodule : timing_derive

`default_nettype wire

// ---- timing_field.sv ----
// one override-enable bit and seven-bit value of a timing register
`timescale 1ns/1ps
`default_nettype none

module timing_field
   import dphy_timing_pkg::*;
#(
   parameter logic [VALUE_W-1:0] RESET_VALUE = 7'h00
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_byte,
   input wire logic [VALUE_W-1:0] i_derived,
   output logic o_override,
   output logic [VALUE_W-1:0] o_applied,
   output logic [7:0] o_read_byte
);

   logic override_reg;
   logic [VALUE_W-1:0] value_reg;

   // RULE_10: override always writable
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         override_reg <= 1'b0;
      end else if (i_wr_en) begin
         override_reg <= i_wr_byte[OVERRIDE_BIT];
      end
   end

   // RULE_08: value kept only with override
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         value_reg <= RESET_VALUE;
      end else if (i_wr_en && i_wr_byte[OVERRIDE_BIT]) begin
         value_reg <= i_wr_byte[VALUE_MSB:0];
      end
   end

   // RULE_07: read-only derived view
   assign o_applied = override_reg ? value_reg : i_derived;
   assign o_override = override_reg;
   assign o_read_byte = {override_reg, o_applied};

endmodule : timing_field

`default_nettype wire

// ---- dphy_hs_timing_override_regs.sv ----
// axi4-lite register bank overriding d-phy high-speed entry and exit timing
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: clock prepare override, value reset 0x5
// RULE_02: clock zero override, value reset 0x1B
// RULE_03: clock trail override, value reset 0x0B
// RULE_04: clock post override, value reset 0x0A
// RULE_05: data prepare override, value reset 0x6
// RULE_06: data zero override, value reset 0x0C
// RULE_07: override clear: value reads derived, read-only
// RULE_08: override set: value writable, read back, applied
// RULE_09: derived values follow rate, 800 default
// RULE_10: value writes ignored without override; bit writable
module dphy_hs_timing_override_regs
   import dphy_timing_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // write address channel
   input wire logic i_awvalid,
   output logic o_awready,
   input wire axi_addr_type i_aw,
   // write data channel
   input wire logic i_wvalid,
   output logic o_wready,
   input wire axi_wdata_type i_w,
   // write response channel
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // read address channel
   input wire logic i_arvalid,
   output logic o_arready,
   input wire axi_addr_type i_ar,
   // read data channel
   output logic o_rvalid,
   input wire logic i_rready,
   output axi_rdata_type o_r,
   // timing applied by the transmitter
   output timing_vec_type o_applied_timing,
   output logic [NUM_PARAMS-1:0] o_override_active,
   output rate_type o_lane_rate
);

   ////////////////////////////////////////////////////////////////////////////////
   // types and declarations

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESPOND = 2'b10
   } wr_state_type;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESPOND = 2'b10
   } rd_state_type;

   localparam logic [7:0] TIMING_IDX [NUM_PARAMS] = '{
      IDX_CLK_PREPARE, IDX_CLK_ZERO, IDX_CLK_TRAIL,
      IDX_CLK_POST, IDX_HS_PREPARE, IDX_HS_ZERO
   };

   localparam timing_vec_type RESET_VALUES = DERIVED_800;

   wr_state_type wr_state_reg;
   wr_state_type wr_state_next;
   rd_state_type rd_state_reg;
   rd_state_type rd_state_next;

   logic aw_held_reg;
   logic w_held_reg;
   axi_addr_type aw_reg;
   axi_wdata_type w_reg;
   logic [1:0] bresp_reg;
   axi_rdata_type r_reg;
   rate_type rate_reg;

   logic aw_take;
   logic w_take;
   logic aw_have;
   logic w_have;
   axi_addr_type aw_cur;
   axi_wdata_type w_cur;
   logic wr_fire;
   logic wr_lane0;
   logic [7:0] wr_byte;
   logic ar_take;

   timing_vec_type derived;
   timing_vec_type applied;
   logic [NUM_PARAMS-1:0] override_bits;
   logic [NUM_PARAMS-1:0][7:0] read_bytes;
   logic [NUM_PARAMS-1:0] field_wr;

   ////////////////////////////////////////////////////////////////////////////////
   // address decoding helpers

   // word aligned and inside the map; misaligned addresses are unmapped
   function automatic logic addr_hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      addr_hits = (addr == byte_addr(idx));
   endfunction : addr_hits

   function automatic logic addr_is_timing(input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_PARAMS; i++) begin
         hit = hit | addr_hits(addr, TIMING_IDX[i]);
      end
      addr_is_timing = hit;
   endfunction : addr_is_timing

   function automatic logic addr_is_writable(input logic [ADDR_W-1:0] addr);
      addr_is_writable = addr_is_timing(addr) || addr_hits(addr, IDX_LANE_RATE);
   endfunction : addr_is_writable

   function automatic logic addr_is_mapped(input logic [ADDR_W-1:0] addr);
      addr_is_mapped = addr_is_writable(addr) || addr_hits(addr, IDX_OVERRIDE_STATUS);
   endfunction : addr_is_mapped

   ////////////////////////////////////////////////////////////////////////////////
   // write channel: address and data accepted in either order

   assign o_awready = (wr_state_reg == WR_COLLECT) && !aw_held_reg;
   assign o_wready = (wr_state_reg == WR_COLLECT) && !w_held_reg;
   assign aw_take = i_awvalid && o_awready;
   assign w_take = i_wvalid && o_wready;
   assign aw_have = aw_held_reg || aw_take;
   assign w_have = w_held_reg || w_take;
   assign aw_cur = aw_held_reg ? aw_reg : i_aw;
   assign w_cur = w_held_reg ? w_reg : i_w;
   assign wr_fire = (wr_state_reg == WR_COLLECT) && aw_have && w_have;
   // registers are one byte wide, so only lane 0 carries a write
   assign wr_lane0 = w_cur.strb[0];
   assign wr_byte = w_cur.data[7:0];

   always_comb begin
      wr_state_next = wr_state_reg;
      case (wr_state_reg)
         WR_COLLECT: begin
            if (wr_fire) begin
               wr_state_next = WR_RESPOND;
            end
         end
         WR_RESPOND: begin
            if (i_bready) begin
               wr_state_next = WR_COLLECT;
            end
         end
         default: wr_state_next = WR_COLLECT;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_state_reg <= WR_COLLECT;
      end else begin
         wr_state_reg <= wr_state_next;
      end
   end

   // hold whichever half arrives first until the other one shows up
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held_reg <= 1'b0;
         aw_reg <= '0;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end else if (aw_take) begin
         aw_held_reg <= 1'b1;
         aw_reg <= i_aw;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_held_reg <= 1'b0;
         w_reg <= '0;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end else if (w_take) begin
         w_held_reg <= 1'b1;
         w_reg <= i_w;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bresp_reg <= RESP_OKAY;
      end else if (wr_fire) begin
         bresp_reg <= addr_is_writable(aw_cur.addr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   assign o_bvalid = (wr_state_reg == WR_RESPOND);
   assign o_bresp = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // timing registers

   always_comb begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
         field_wr[i] = wr_fire && wr_lane0 && addr_hits(aw_cur.addr, TIMING_IDX[i]);
      end
   end

   timing_derive u_derive (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_rate(rate_reg),
      .o_derived(derived)
   );

   // RULE_01: clock-lane prepare
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_CLK_PREPARE])) u_clk_prepare (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_CLK_PREPARE]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_CLK_PREPARE]),
      .o_override(override_bits[SLOT_CLK_PREPARE]),
      .o_applied(applied[SLOT_CLK_PREPARE]),
      .o_read_byte(read_bytes[SLOT_CLK_PREPARE])
   );

   // RULE_02: clock-lane zero
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_CLK_ZERO])) u_clk_zero (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_CLK_ZERO]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_CLK_ZERO]),
      .o_override(override_bits[SLOT_CLK_ZERO]),
      .o_applied(applied[SLOT_CLK_ZERO]),
      .o_read_byte(read_bytes[SLOT_CLK_ZERO])
   );

   // RULE_03: clock-lane trail
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_CLK_TRAIL])) u_clk_trail (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_CLK_TRAIL]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_CLK_TRAIL]),
      .o_override(override_bits[SLOT_CLK_TRAIL]),
      .o_applied(applied[SLOT_CLK_TRAIL]),
      .o_read_byte(read_bytes[SLOT_CLK_TRAIL])
   );

   // RULE_04: clock-lane post
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_CLK_POST])) u_clk_post (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_CLK_POST]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_CLK_POST]),
      .o_override(override_bits[SLOT_CLK_POST]),
      .o_applied(applied[SLOT_CLK_POST]),
      .o_read_byte(read_bytes[SLOT_CLK_POST])
   );

   // RULE_05: data-lane prepare
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_HS_PREPARE])) u_hs_prepare (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_HS_PREPARE]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_HS_PREPARE]),
      .o_override(override_bits[SLOT_HS_PREPARE]),
      .o_applied(applied[SLOT_HS_PREPARE]),
      .o_read_byte(read_bytes[SLOT_HS_PREPARE])
   );

   // RULE_06: data-lane zero
   timing_field #(.RESET_VALUE(RESET_VALUES[SLOT_HS_ZERO])) u_hs_zero (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(field_wr[SLOT_HS_ZERO]),
      .i_wr_byte(wr_byte),
      .i_derived(derived[SLOT_HS_ZERO]),
      .o_override(override_bits[SLOT_HS_ZERO]),
      .o_applied(applied[SLOT_HS_ZERO]),
      .o_read_byte(read_bytes[SLOT_HS_ZERO])
   );

   // RULE_09: rate select steers derivation
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rate_reg <= RATE_RESET;
      end else if (wr_fire && wr_lane0 && addr_hits(aw_cur.addr, IDX_LANE_RATE)) begin
         rate_reg <= rate_type'(wr_byte[RATE_W-1:0]);
      end
   end

   // RULE_08: transmitter sees chosen value
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_applied_timing <= RESET_VALUES;
         o_override_active <= '0;
      end else begin
         o_applied_timing <= applied;
         o_override_active <= override_bits;
      end
   end

   assign o_lane_rate = rate_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // read channel: one outstanding read, data registered

   assign o_arready = (rd_state_reg == RD_IDLE);
   assign ar_take = i_arvalid && o_arready;

   always_comb begin
      rd_state_next = rd_state_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (ar_take) begin
               rd_state_next = RD_RESPOND;
            end
         end
         RD_RESPOND: begin
            if (i_rready) begin
               rd_state_next = RD_IDLE;
            end
         end
         default: rd_state_next = RD_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_state_reg <= RD_IDLE;
      end else begin
         rd_state_reg <= rd_state_next;
      end
   end

   function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] addr);
      logic [7:0] val;
      val = 8'h00;
      for (int i = 0; i < NUM_PARAMS; i++) begin
         if (addr_hits(addr, TIMING_IDX[i])) begin
            val = read_bytes[i];
         end
      end
      if (addr_hits(addr, IDX_LANE_RATE)) begin
         val = {{(8-RATE_W){1'b0}}, rate_reg};
      end
      if (addr_hits(addr, IDX_OVERRIDE_STATUS)) begin
         val = {{(8-NUM_PARAMS){1'b0}}, override_bits};
      end
      return val;
   endfunction : read_mux

   // RULE_07: value sampled at address acceptance
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else if (ar_take) begin
         r_reg.data <= {24'h000000, read_mux(i_ar.addr)};
         r_reg.resp <= addr_is_mapped(i_ar.addr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   assign o_rvalid = (rd_state_reg == RD_RESPOND);
   assign o_r = r_reg;

endmodule : dphy_hs_timing_override_regs

`default_nettype wire

// ---- dphy_regs_checker.sv ----
// port assertions for the timing override register bank
`timescale 1ns/1ps
`default_nettype none

module dphy_regs_checker
   import dphy_timing_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire axi_addr_type i_ar,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire axi_rdata_type o_r,
   input wire timing_vec_type o_applied_timing,
   input wire logic [NUM_PARAMS-1:0] o_override_active,
   input wire rate_type o_lane_rate
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read not answered one cycle after address");
   rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_r))
      else $error("read data dropped before rready");
   rd_upper_zero_a: assert property (o_rvalid |-> o_r.data[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   rd_unmapped_a: assert property (i_arvalid && o_arready && i_ar.addr[11:8] == 4'h0
      |=> o_r.resp == RESP_SLVERR && o_r.data == 32'h0)
      else $error("unmapped read not refused");
   rd_block_a: assert property (o_rvalid |-> !o_arready)
      else $error("read address accepted while read pending");
   wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready
      |=> o_bvalid)
      else $error("write not answered one cycle after address and data");
   wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped before bready");
   wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write accepted while response pending");
   // two edges of latency from rate to applied timing; four samples cover it with one to spare
   derived_rate_a: assert property ((o_override_active == 6'h0
      && o_lane_rate == RATE_800) [*4] |-> o_applied_timing == DERIVED_800)
      else $error("applied timing differs from derived 800 table");
endmodule : dphy_regs_checker

bind dphy_hs_timing_override_regs dphy_regs_checker u_chk (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
   .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .i_ar(i_ar), .o_rvalid(o_rvalid),
   .i_rready(i_rready), .o_r(o_r), .o_applied_timing(o_applied_timing),
   .o_override_active(o_override_active), .o_lane_rate(o_lane_rate));

`default_nettype wire

// ---- csi_rx_model.sv ----
// receiver-side capture of the timing the transmitter applies
`timescale 1ns/1ps
`default_nettype none

module csi_rx_model
   import dphy_timing_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire timing_vec_type i_timing,
   input wire logic [NUM_PARAMS-1:0] i_override,
   output timing_vec_type o_seen,
   output logic [NUM_PARAMS-1:0] o_seen_override
);
   // one cycle late, like a receiver latching its timing set
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_seen <= '0;
         o_seen_override <= '0;
      end else begin
         o_seen <= i_timing;
         o_seen_override <= i_override;
      end
   end
endmodule : csi_rx_model

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the timing override register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import dphy_timing_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   axi_addr_type aw = '0;
   axi_addr_type ar = '0;
   axi_wdata_type w = '0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp;
   axi_rdata_type o_r;
   timing_vec_type o_applied_timing, seen;
   logic [NUM_PARAMS-1:0] o_override_active, seen_ov;
   rate_type o_lane_rate;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed;
   logic [5:0] ov = '0;
   logic [6:0] val [6];
   int rate = 0;
   // lag holds back bready/rready by one cycle so the slave must keep its answer standing
   logic lag = 1'b0;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] rst_tab [6] = '{8'h05, 8'h1b, 8'h0b, 8'h0a, 8'h06, 8'h0c};

   dphy_hs_timing_override_regs DUT (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_awvalid(awvalid), .o_awready(o_awready), .i_aw(aw), .i_wvalid(wvalid),
      .o_wready(o_wready), .i_w(w), .o_bvalid(o_bvalid), .i_bready(bready),
      .o_bresp(o_bresp), .i_arvalid(arvalid), .o_arready(o_arready), .i_ar(ar),
      .o_rvalid(o_rvalid), .i_rready(rready), .o_r(o_r),
      .o_applied_timing(o_applied_timing), .o_override_active(o_override_active),
      .o_lane_rate(o_lane_rate));
   csi_rx_model rx (.i_sys_clk(clk), .i_rst_n(rst_n), .i_timing(o_applied_timing),
      .i_override(o_override_active), .o_seen(seen), .o_seen_override(seen_ov));

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   // ready and valid read right after the edge still hold their pre-edge values
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic done;
      @(posedge clk);
      done = 1'b0;
      r = 2'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !lag;
      aw <= '{addr: a, prot: 3'h0};
      w <= '{data: {24'h0, d}, strb: wstrb};
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clk);
         if (bready && o_bvalid) begin
            r = o_bresp;
            done = 1'b1;
            bready <= 1'b0;
         end else if (o_bvalid) begin
            bready <= 1'b1;
         end
         if (awvalid && o_awready) awvalid <= 1'b0;
         if (wvalid && o_wready) wvalid <= 1'b0;
      end
      if (!done) fail_count++;
   endtask : wr

   task automatic rd(input logic [11:0] a, output axi_rdata_type r);
      logic done;
      @(posedge clk);
      done = 1'b0;
      r = '1;
      arvalid <= 1'b1;
      rready <= !lag;
      ar <= '{addr: a, prot: 3'h0};
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clk);
         if (rready && o_rvalid) begin
            r = o_r;
            done = 1'b1;
            rready <= 1'b0;
         end else if (o_rvalid) begin
            rready <= 1'b1;
         end
         if (arvalid && o_arready) arvalid <= 1'b0;
      end
      if (!done) fail_count++;
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] exp_reg(input int i);
      timing_vec_type t;
      case (rate)
         0: t = DERIVED_800;
         1: t = DERIVED_400;
         2: t = DERIVED_1200;
         default: t = DERIVED_1600;
      endcase
      exp_reg = ov[i] ? {1'b1, val[i]} : {1'b0, t[i]};
   endfunction : exp_reg

   task automatic reg_wr(input int i, input logic [7:0] d);
      logic [1:0] r;
      wr(12'h100 + 12'(4 * i), d, r);
      if (d[7]) val[i] = d[6:0];
      ov[i] = d[7];
      chk({30'h0, RESP_OKAY}, {30'h0, r});
   endtask : reg_wr

   task automatic sweep();
      axi_rdata_type r;
      logic [7:0] e;
      for (int i = 0; i < NUM_PARAMS; i++) begin
         rd(12'h100 + 12'(4 * i), r);
         e = exp_reg(i);
         chk({24'h0, e}, r.data);
         chk({30'h0, RESP_OKAY}, {30'h0, r.resp});
         chk({25'h0, e[6:0]}, {25'h0, seen[i]});
      end
      chk({26'h0, ov}, {26'h0, seen_ov});
   endtask : sweep

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      axi_rdata_type r;
      logic [1:0] b;
      seed = $urandom(32'h9c6c);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < NUM_PARAMS; i++) begin
         rd(12'h100 + 12'(4 * i), r);
         chk({24'h0, rst_tab[i]}, r.data);
      end
      for (int i = 0; i < NUM_PARAMS; i++) begin
         reg_wr(i, {1'b0, 7'($urandom)});
         sweep();
         reg_wr(i, {1'b1, 7'($urandom)});
         sweep();
      end
      // clearing overrides on some registers leaves a mix under each rate
      for (int k = 0; k < 4; k++) begin
         wr(12'h120, 8'(k), b);
         rate = k;
         reg_wr(k, {1'b0, 7'($urandom)});
         chk(32'(k), {30'h0, o_lane_rate});
         sweep();
      end
      wr(12'h0fc, 8'h85, b);
      chk({30'h0, RESP_SLVERR}, {30'h0, b});
      wr(12'h101, 8'h85, b);
      chk({30'h0, RESP_SLVERR}, {30'h0, b});
      rd(12'h000, r);
      chk({30'h0, RESP_SLVERR}, {30'h0, r.resp});
      chk(32'h0, r.data);
      // late ready on the answer, and the rate and status registers
      lag = 1'b1;
      rd(12'h120, r);
      chk(32'(rate), r.data);
      rd(12'h124, r);
      chk({26'h0, ov}, r.data);
      wr(12'h124, 8'h3f, b);
      chk({30'h0, RESP_SLVERR}, {30'h0, b});
      lag = 1'b0;
      // byte lane 0 disabled: accepted, nothing changes
      wstrb = 4'he;
      wr(12'h110, 8'hff, b);
      chk({30'h0, RESP_OKAY}, {30'h0, b});
      wstrb = 4'hf;
      sweep();
      test_done();
   end
endmodule : tb_top

`default_nettype wire
